// File: logic/group_apply.sv
// Purpose: map one level's logical preset row onto physical outputs
// Assumes: grp is already forced to at least one
// Notes: purely combinational
`timescale 1ns/1ps
module group_apply
	import router_pkg::*;
(
	input wire logic [GRP_W-1:0] grp,
	input wire row_t preset_row,
	input wire row_t cur_row,
	output row_t nxt_row
);
	logic [GRP_W-1:0] dims;

	assign dims = PHYS_IO / grp;

	// ****************************************
	// per physical output
	// ****************************************
	for (genvar p = 0; p < NUM_DST; p++) begin : g_out
		localparam logic [GRP_W-1:0] PIDX = GRP_W'(p);
		logic [GRP_W-1:0] d;
		logic [GRP_W-1:0] k;
		logic [SRC_W-1:0] v;
		assign d = PIDX / grp;
		assign k = PIDX % grp;
		assign v = preset_row[d[1:0]];
		// unassigned entries leave the output alone; groups move together
		assign nxt_row[p] = (d >= dims || v == SRC_KEEP || v > {1'b0, dims}) ? cur_row[p] :
			(v == SRC_MUTE) ? SRC_MUTE : (v - 4'h1) * {1'b0, grp} + {1'b0, k} + 4'h1;
	end
endmodule : group_apply

// File: logic/router_matrix_cmd_interp.sv
// Purpose: command interpreter for matrix config, grouping, netmask and preset recall
// Assumes: commands arrive already split into opcode and arguments
// Notes: replies leave as a stream of items, one line of text each
`timescale 1ns/1ps
// How it works
// - config flags 1 labels, 2 state, 4 presets
// - bare config query gives per-level count triples
// - capability sum weights mute 1, lock 2, reclk 4
// - argument 0 to 7 gives descriptive reply
// - descriptive reply carries one status keyword
// - every label holds eight characters at most
// - each level reports its type keyword
// - descriptive capabilities sent as keywords
// - sources one-based, zero mute, minus one keep
// - config query supplies dims, labels, state, presets
// - grouping divides apparent dimensions by count
// - grouped outputs switch together on routing change
// - each level keeps its own group count
// - group command queries or sets levels one, two
// - grouping and netmask restored after power up
// - netmask command queries or replaces mask
// - ten presets, recall applies chosen one
// - recall touches only assigned destinations
// - preset zero recalled after every power up
module router_matrix_cmd_interp
	import router_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire router_pkg::cmd_t cmd_i,
	output logic cmd_ready,
	output router_pkg::rep_item_t rep_item,
	output logic rep_valid,
	input wire logic rep_ready,
	input wire router_pkg::mtx_status_t mtx_status,
	input wire router_pkg::pset_wr_t pset_wr,
	input wire router_pkg::lbl_wr_t lbl_wr,
	input wire router_pkg::nv_t nv_in,
	output router_pkg::nv_t nv_out,
	output logic nv_save,
	output router_pkg::matrix_t route
);
	import router_pkg::*;

	typedef enum logic [3:0] {ST_BOOT = 4'b0001, ST_RECALL = 4'b0010, ST_IDLE = 4'b0100,
		ST_EMIT = 4'b1000} state_t;
	typedef enum logic [1:0] {MD_SIMPLE, MD_FULL, MD_GROUP, MD_MASK} mode_t;

	state_t state_q;
	mode_t mode_q;
	sec_t sec_q;
	sec_t nxt_sec;
	sec_t first_sec;
	sec_t last_sec;
	logic lvl_q;
	logic [3:0] idx_q;
	logic [3:0] sec_len;
	logic [2:0] flags_q;
	logic [3:0] psel_q;
	logic booted_q;
	logic cmd_ready_q;
	logic rep_valid_q;
	rep_item_t rep_item_q;
	rep_item_t item;
	logic emit;
	logic last_idx;
	logic slot;
	logic accept;
	logic grp_ok;
	nv_t nv_q;
	logic nv_save_q;
	matrix_t route_q;
	matrix_t recall_row;
	row_t pset_q [NUM_PSET][NUM_LVL];
	logic [LBL_W-1:0] dlbl_q [NUM_LVL][NUM_DST];
	logic [LBL_W-1:0] slbl_q [NUM_LVL][NUM_DST];
	logic [LBL_W-1:0] plbl_q [NUM_PSET];
	logic [GRP_W-1:0] g_eff [NUM_LVL];
	logic [GRP_W-1:0] dims [NUM_LVL];

	assign cmd_ready = cmd_ready_q;
	assign rep_valid = rep_valid_q;
	assign rep_item = rep_item_q;
	assign nv_out = nv_q;
	assign nv_save = nv_save_q;
	assign route = route_q;
	assign slot = !rep_valid_q || rep_ready;
	assign accept = state_q == ST_IDLE && cmd_valid && cmd_ready_q;
	assign grp_ok = cmd_i.arg0 <= 32'(MAX_GRP) && (cmd_i.argc < 2'h2 || cmd_i.arg1 <= 32'(MAX_GRP));

	// ****************************************
	// grouping per level
	// ****************************************
	for (genvar l = 0; l < NUM_LVL; l++) begin : g_lvl
		// zero and one both mean ungrouped
		assign g_eff[l] = (nv_q.grp[l] <= 3'h1) ? 3'h1 : nv_q.grp[l];
		assign dims[l] = PHYS_IO / g_eff[l];
		group_apply u_apply (
			.grp(g_eff[l]),
			.preset_row(pset_q[psel_q][l]),
			.cur_row(route_q[l]),
			.nxt_row(recall_row[l])
		);
	end

	// ****************************************
	// reply sequencing
	// ****************************************
	always_comb begin
		sec_len = 4'h1;
		case (sec_q)
			SEC_CAPS: sec_len = 4'h3;
			SEC_DLBL, SEC_SLBL: sec_len = flags_q[FLAG_LABEL_BIT] ? {1'b0, dims[lvl_q]} : 4'h0;
			SEC_STATE: sec_len = flags_q[FLAG_STATE_BIT] ? 4'h1 : 4'h0;
			SEC_PSET: sec_len = flags_q[FLAG_PSET_BIT] ? PSET_COUNT : 4'h0;
			SEC_PLBL: sec_len = flags_q[FLAG_LABEL_BIT] ? PSET_COUNT : 4'h0;
			default: sec_len = 4'h1;
		endcase
		emit = sec_len != 4'h0 && (sec_q != SEC_CAPS || LVL_CAPS[lvl_q][idx_q[1:0]]);
		last_idx = sec_len == 4'h0 || idx_q == sec_len - 4'h1;
		first_sec = (mode_q == MD_SIMPLE) ? SEC_DIMS : (mode_q == MD_GROUP) ? SEC_GROUP : SEC_TYPE;
		last_sec = (mode_q == MD_SIMPLE) ? SEC_DIMS : (mode_q == MD_GROUP) ? SEC_GROUP : SEC_PSET;
		case (sec_q)
			SEC_MASK, SEC_ERR, SEC_PLBL, SEC_PROMPT: nxt_sec = SEC_PROMPT;
			default: begin
				if (sec_q == last_sec) begin
					nxt_sec = !lvl_q ? first_sec : (mode_q == MD_FULL) ? SEC_PLBL : SEC_PROMPT;
				end else begin
					nxt_sec = sec_t'(sec_q + 4'h1);
				end
			end
		endcase
	end

	// ****************************************
	// reply item contents
	// ****************************************
	always_comb begin
		row_t lrow;
		logic [SRC_W-1:0] s;
		lrow = '0;
		s = '0;
		for (int d = 0; d < NUM_DST; d++) begin
			if (3'(d) < dims[lvl_q]) begin
				s = route_q[lvl_q][2'(3'(d) * g_eff[lvl_q])];
				lrow[d] = (s == SRC_MUTE) ? SRC_MUTE : (s - 4'h1) / {1'b0, g_eff[lvl_q]} + 4'h1;
			end
		end
		item.kind = sec_q;
		item.lvl = lvl_q;
		item.idx = idx_q;
		item.value = '0;
		case (sec_q)
			SEC_STATUS: item.value = status_kw(mtx_status);
			SEC_TYPE: item.value = type_kw(LVL_TYPE[lvl_q]);
			SEC_CAPS: item.value = cap_kw(idx_q[1:0]);
			SEC_DIMS: begin
				item.value[23:16] = {5'h0, dims[lvl_q]};
				item.value[15:8] = {5'h0, dims[lvl_q]};
				if (mode_q == MD_SIMPLE) begin
					item.value[2:0] = LVL_CAPS[lvl_q];
				end
			end
			SEC_DLBL: item.value[LBL_W-1:0] = dlbl_q[lvl_q][2'(idx_q[2:0] * g_eff[lvl_q])];
			SEC_SLBL: item.value[LBL_W-1:0] = slbl_q[lvl_q][2'(idx_q[2:0] * g_eff[lvl_q])];
			SEC_STATE: item.value[15:0] = lrow;
			SEC_PSET: item.value[15:0] = pset_q[idx_q][lvl_q];
			SEC_PLBL: item.value[LBL_W-1:0] = plbl_q[idx_q];
			SEC_GROUP: item.value[GRP_W-1:0] = nv_q.grp[lvl_q];
			SEC_MASK: item.value[31:0] = nv_q.mask;
			SEC_ERR: item.value = TXT_W'("ERROR");
			default: item.value = TXT_W'(">");
		endcase
	end

	// ****************************************
	// control state machine
	// ****************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_BOOT;
			mode_q <= MD_SIMPLE;
			sec_q <= SEC_PROMPT;
			lvl_q <= 1'b0;
			idx_q <= 4'h0;
			flags_q <= 3'h0;
			psel_q <= PSET_BOOT;
			booted_q <= 1'b0;
			cmd_ready_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_BOOT: begin
					psel_q <= PSET_BOOT;
					state_q <= ST_RECALL;
				end
				ST_RECALL: begin
					booted_q <= 1'b1;
					state_q <= booted_q ? ST_EMIT : ST_IDLE;
					cmd_ready_q <= !booted_q;
				end
				ST_IDLE: begin
					if (accept) begin
						cmd_ready_q <= 1'b0;
						lvl_q <= 1'b0;
						idx_q <= 4'h0;
						state_q <= ST_EMIT;
						sec_q <= SEC_ERR;
						case (cmd_i.op)
							OP_MATRIX_CONFIG_QUERY: begin
								if (cmd_i.argc == 2'h0) begin
									mode_q <= MD_SIMPLE;
									sec_q <= SEC_DIMS;
								end else if (cmd_i.arg0 <= MAX_FLAGS) begin
									mode_q <= MD_FULL;
									flags_q <= cmd_i.arg0[2:0];
									sec_q <= SEC_STATUS;
								end
							end
							OP_IO_GROUP_CMD: begin
								if (cmd_i.argc == 2'h0) begin
									mode_q <= MD_GROUP;
									sec_q <= SEC_GROUP;
								end else if (grp_ok) begin
									sec_q <= SEC_PROMPT;
								end
							end
							OP_NET_MASK: begin
								mode_q <= MD_MASK;
								sec_q <= (cmd_i.argc == 2'h0) ? SEC_MASK : SEC_PROMPT;
							end
							OP_PRESET_RECALL: begin
								if (cmd_i.argc != 2'h0 && cmd_i.arg0 <= MAX_PSET) begin
									psel_q <= cmd_i.arg0[3:0];
									sec_q <= SEC_PROMPT;
									state_q <= ST_RECALL;
								end
							end
							default: sec_q <= SEC_ERR;
						endcase
					end
				end
				ST_EMIT: begin
					if (slot) begin
						if (sec_q == SEC_PROMPT) begin
							state_q <= ST_IDLE;
							cmd_ready_q <= 1'b1;
						end else if (last_idx) begin
							sec_q <= nxt_sec;
							lvl_q <= lvl_q | (sec_q == last_sec);
							idx_q <= 4'h0;
						end else begin
							idx_q <= idx_q + 4'h1;
						end
					end
				end
			endcase
		end
	end

	// ****************************************
	// reply output register
	// ****************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rep_valid_q <= 1'b0;
			rep_item_q <= '0;
		end else if (slot) begin
			rep_valid_q <= state_q == ST_EMIT && emit;
			rep_item_q <= item;
		end
	end

	// ****************************************
	// stored settings
	// ****************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			nv_q <= '0;
			nv_save_q <= 1'b0;
		end else begin
			nv_save_q <= 1'b0;
			if (state_q == ST_BOOT) begin
				nv_q <= nv_in;
			end else if (accept && cmd_i.op == OP_IO_GROUP_CMD && cmd_i.argc != 2'h0 && grp_ok) begin
				nv_q.grp[0] <= cmd_i.arg0[GRP_W-1:0];
				if (cmd_i.argc >= 2'h2) begin
					nv_q.grp[1] <= cmd_i.arg1[GRP_W-1:0];
				end
				nv_save_q <= 1'b1;
			end else if (accept && cmd_i.op == OP_NET_MASK && cmd_i.argc != 2'h0) begin
				nv_q.mask <= cmd_i.arg0;
				nv_save_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// matrix routing
	// ****************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int l = 0; l < NUM_LVL; l++) begin
				for (int d = 0; d < NUM_DST; d++) begin
					route_q[l][d] <= SRC_W'(d + 1);
				end
			end
		end else if (state_q == ST_RECALL) begin
			route_q <= recall_row;
		end
	end

	// ****************************************
	// preset and label stores
	// ****************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int p = 0; p < NUM_PSET; p++) begin
				plbl_q[p] <= '0;
				for (int l = 0; l < NUM_LVL; l++) begin
					pset_q[p][l] <= {NUM_DST{SRC_KEEP}};
				end
			end
			for (int l = 0; l < NUM_LVL; l++) begin
				for (int d = 0; d < NUM_DST; d++) begin
					dlbl_q[l][d] <= '0;
					slbl_q[l][d] <= '0;
				end
			end
		end else begin
			if (pset_wr.we && pset_wr.num < PSET_COUNT) begin
				pset_q[pset_wr.num][pset_wr.lvl][pset_wr.dest] <= pset_wr.src;
			end
			if (lbl_wr.we) begin
				if (lbl_wr.kind == LBL_DEST) begin
					dlbl_q[lbl_wr.lvl][lbl_wr.idx[1:0]] <= lbl_wr.text;
				end else if (lbl_wr.kind == LBL_SRC) begin
					slbl_q[lbl_wr.lvl][lbl_wr.idx[1:0]] <= lbl_wr.text;
				end else if (lbl_wr.kind == LBL_PSET && lbl_wr.idx < PSET_COUNT) begin
					plbl_q[lbl_wr.idx] <= lbl_wr.text;
				end
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_boot;
		state_q == ST_BOOT |=> state_q == ST_RECALL && psel_q == PSET_BOOT ##1 state_q == ST_IDLE && cmd_ready_q;
	endproperty
	a_boot: assert property (p_boot) else $error("power-up did not recall preset zero");
	property p_prompt;
		$rose(cmd_ready_q) && $past(booted_q) |-> rep_valid_q && rep_item_q.kind == SEC_PROMPT;
	endproperty
	a_prompt: assert property (p_prompt) else $error("ready returned without prompt");
	property p_busy;
		accept |=> !cmd_ready_q;
	endproperty
	a_busy: assert property (p_busy) else $error("ready stayed high after command");
	property p_recall_range;
		accept && cmd_i.op == OP_PRESET_RECALL && cmd_i.argc != 2'h0 && cmd_i.arg0 > MAX_PSET
			|=> state_q == ST_EMIT && sec_q == SEC_ERR;
	endproperty
	a_recall_range: assert property (p_recall_range) else $error("bad preset not refused");
	property p_cfg_full;
		accept && cmd_i.op == OP_MATRIX_CONFIG_QUERY && cmd_i.argc != 2'h0 && cmd_i.arg0 <= MAX_FLAGS
			|=> sec_q == SEC_STATUS && mode_q == MD_FULL && flags_q == $past(cmd_i.arg0[2:0]);
	endproperty
	a_cfg_full: assert property (p_cfg_full) else $error("descriptive reply not started");
	property p_simple_caps;
		rep_valid_q && rep_item_q.kind == SEC_DIMS && mode_q == MD_SIMPLE
			|-> rep_item_q.value[2:0] == LVL_CAPS[rep_item_q.lvl];
	endproperty
	a_simple_caps: assert property (p_simple_caps) else $error("capability sum wrong");
	property p_dims;
		rep_valid_q && rep_item_q.kind == SEC_DIMS |-> rep_item_q.value[23:16] == rep_item_q.value[15:8]
			&& rep_item_q.value[23:16] * {5'h0, g_eff[rep_item_q.lvl]} <= {5'h0, PHYS_IO}
			&& (rep_item_q.value[23:16] + 8'h1) * {5'h0, g_eff[rep_item_q.lvl]} > {5'h0, PHYS_IO};
	endproperty
	a_dims: assert property (p_dims) else $error("grouped dimension wrong");
	property p_status;
		rep_valid_q && rep_item_q.kind == SEC_STATUS && $rose(rep_valid_q) |-> rep_item_q.value == status_kw($past(mtx_status));
	endproperty
	a_status: assert property (p_status) else $error("status keyword wrong");
	property p_group_set;
		accept && cmd_i.op == OP_IO_GROUP_CMD && cmd_i.argc == 2'h2 && grp_ok |=> nv_save_q
			&& nv_q.grp[0] == $past(cmd_i.arg0[GRP_W-1:0]) && nv_q.grp[1] == $past(cmd_i.arg1[GRP_W-1:0]);
	endproperty
	a_group_set: assert property (p_group_set) else $error("group counts not stored");
	property p_mask_set;
		accept && cmd_i.op == OP_NET_MASK && cmd_i.argc != 2'h0 |=> nv_save_q && nv_q.mask == $past(cmd_i.arg0);
	endproperty
	a_mask_set: assert property (p_mask_set) else $error("netmask not stored");

	c_full_reply: cover property (rep_valid_q && rep_item_q.kind == SEC_PLBL && rep_ready);
	c_recall: cover property (state_q == ST_RECALL && booted_q);
	c_group_set: cover property (nv_save_q && nv_q.grp[0] == 3'h4);
endmodule : router_matrix_cmd_interp

// File: logic/router_pkg.sv
// Purpose: shared types and constants for the router command interpreter
// Assumes: two levels, four physical destinations and sources per level
// Notes: reply text fields are ascii, right aligned, zero filled
package router_pkg;
	// ****************************************
	// sizes and encodings
	// ****************************************
	localparam int NUM_LVL = 2;
	localparam int NUM_DST = 4;
	localparam int NUM_PSET = 10;
	localparam int SRC_W = 4;
	localparam int GRP_W = 3;
	localparam int TXT_W = 80;
	localparam int LBL_W = 64;
	localparam logic [GRP_W-1:0] PHYS_IO = 3'h4;
	localparam logic [GRP_W-1:0] MAX_GRP = 3'h4;
	localparam logic [31:0] MAX_FLAGS = 32'h7;
	localparam logic [31:0] MAX_PSET = 32'h9;
	localparam logic [3:0] PSET_COUNT = 4'ha;
	localparam logic [3:0] PSET_BOOT = 4'h0;
	localparam logic [SRC_W-1:0] SRC_MUTE = 4'h0;
	localparam logic [SRC_W-1:0] SRC_KEEP = 4'hf;
	localparam int FLAG_LABEL_BIT = 0;
	localparam int FLAG_STATE_BIT = 1;
	localparam int FLAG_PSET_BIT = 2;
	localparam int CAP_MUTE_BIT = 0;
	localparam int CAP_LOCK_BIT = 1;
	localparam int CAP_RECLK_BIT = 2;
	localparam logic [1:0] LBL_DEST = 2'h0;
	localparam logic [1:0] LBL_SRC = 2'h1;
	localparam logic [1:0] LBL_PSET = 2'h2;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {LT_VIDEO, LT_AUDIO, LT_HD, LT_VGA, LT_3G, LT_ANALOG, LT_AES} level_type_t;
	typedef enum logic [1:0] {MS_OK, MS_UPDATING, MS_DISCONNECT, MS_ERROR} mtx_status_t;
	typedef enum logic [2:0] {OP_MATRIX_CONFIG_QUERY, OP_IO_GROUP_CMD, OP_NET_MASK, OP_PRESET_RECALL,
		OP_OTHER} opcode_t;
	typedef enum logic [3:0] {SEC_STATUS = 4'h0, SEC_TYPE = 4'h1, SEC_CAPS = 4'h2, SEC_DIMS = 4'h3,
		SEC_DLBL = 4'h4, SEC_SLBL = 4'h5, SEC_STATE = 4'h6, SEC_PSET = 4'h7, SEC_PLBL = 4'h8,
		SEC_GROUP = 4'h9, SEC_MASK = 4'ha, SEC_PROMPT = 4'hb, SEC_ERR = 4'hc} sec_t;
	typedef logic [NUM_DST-1:0][SRC_W-1:0] row_t;
	typedef row_t [NUM_LVL-1:0] matrix_t;
	typedef struct packed {opcode_t op; logic [1:0] argc; logic [31:0] arg0; logic [31:0] arg1;} cmd_t;
	typedef struct packed {sec_t kind; logic lvl; logic [3:0] idx; logic [TXT_W-1:0] value;} rep_item_t;
	typedef struct packed {logic we; logic [3:0] num; logic lvl; logic [1:0] dest; logic [SRC_W-1:0] src;} pset_wr_t;
	typedef struct packed {logic we; logic [1:0] kind; logic lvl; logic [3:0] idx; logic [LBL_W-1:0] text;} lbl_wr_t;
	typedef struct packed {logic [NUM_LVL-1:0][GRP_W-1:0] grp; logic [31:0] mask;} nv_t;

	localparam level_type_t LVL_TYPE [NUM_LVL] = '{LT_VIDEO, LT_AUDIO};
	localparam logic [2:0] LVL_CAPS [NUM_LVL] = '{3'h3, 3'h0};

	// ****************************************
	// keyword text
	// ****************************************
	function automatic logic [TXT_W-1:0] type_kw(level_type_t t);
		case (t)
			LT_VIDEO: return TXT_W'("VIDEO");
			LT_AUDIO: return TXT_W'("AUDIO");
			LT_HD: return TXT_W'("HD");
			LT_VGA: return TXT_W'("VGA");
			LT_3G: return TXT_W'("3G");
			LT_ANALOG: return TXT_W'("ANALOG");
			default: return TXT_W'("AES");
		endcase
	endfunction : type_kw

	function automatic logic [TXT_W-1:0] status_kw(mtx_status_t s);
		case (s)
			MS_OK: return TXT_W'("OK");
			MS_UPDATING: return TXT_W'("UPDATING");
			MS_DISCONNECT: return TXT_W'("DISCONNECT");
			default: return TXT_W'("ERROR");
		endcase
	endfunction : status_kw

	function automatic logic [TXT_W-1:0] cap_kw(logic [1:0] b);
		case (b)
			2'h0: return TXT_W'("mute");
			2'h1: return TXT_W'("lock");
			default: return TXT_W'("reclk");
		endcase
	endfunction : cap_kw
endpackage : router_pkg

// File: tb/host_model.sv
// Purpose: control host side, consumes reply items
// Assumes: bench supplies the stall pattern
// Notes: items taken on edges with rep_valid and rep_ready high
`timescale 1ns/1ps
module host_model
	import router_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic stall,
	input wire logic rep_valid,
	input wire router_pkg::rep_item_t rep_item,
	output logic rep_ready
);
	rep_item_t got_q[$];
	logic valid_s;
	rep_item_t item_s;

	// ********
	// reply sink
	// ********
	initial rep_ready = 1'b0;
	always @(negedge ref_clk) begin
		rep_ready <= resetn & ~stall;
		valid_s <= rep_valid;
		item_s <= rep_item;
	end
	// one item per handshake, prompt closes the reply; outputs read settled
	always @(posedge ref_clk) begin
		if (valid_s === 1'b1 && rep_ready === 1'b1) got_q.push_back(item_s);
	end
endmodule : host_model

// File: tb/router_matrix_cmd_interp_tb_top.sv
// Purpose: self-checking bench for the router command interpreter
// Assumes: host_model takes replies with random stalls
// Notes: inputs change on the falling edge of ref_clk
`timescale 1ns/1ps
module router_matrix_cmd_interp_tb_top;
	import router_pkg::*;
	logic ref_clk, resetn, cmd_valid, cmd_ready, rep_valid, rep_ready, nv_save, stall;
	cmd_t cmd_i;
	rep_item_t rep_item;
	rep_item_t q[$];
	mtx_status_t mtx_status;
	pset_wr_t pset_wr;
	lbl_wr_t lbl_wr;
	nv_t nv_in, nv_out;
	matrix_t route, straight, exp_route;
	logic [15:0] rnd;
	logic [GRP_W-1:0] g0, g1;
	logic [31:0] mask;
	int bad_count, comparisons, saves, cycles, n;

	router_matrix_cmd_interp u_router_matrix_cmd_interp (.ref_clk(ref_clk), .resetn(resetn),
		.cmd_valid(cmd_valid), .cmd_i(cmd_i), .cmd_ready(cmd_ready), .rep_item(rep_item),
		.rep_valid(rep_valid), .rep_ready(rep_ready), .mtx_status(mtx_status), .pset_wr(pset_wr),
		.lbl_wr(lbl_wr), .nv_in(nv_in), .nv_out(nv_out), .nv_save(nv_save), .route(route));
	host_model u_host_model (.ref_clk(ref_clk), .resetn(resetn), .stall(stall), .rep_valid(rep_valid),
		.rep_item(rep_item), .rep_ready(rep_ready));

	// ********
	// expectations
	// ********
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [7:0] dims(input logic [GRP_W-1:0] g);
		return (g < 3'h2) ? 8'h4 : 8'h4 / 8'(g);
	endfunction : dims
	function automatic logic [TXT_W-1:0] stat_txt(input logic [1:0] s);
		case (s)
			2'h0: return TXT_W'("OK");
			2'h1: return TXT_W'("UPDATING");
			2'h2: return TXT_W'("DISCONNECT");
			default: return TXT_W'("ERROR");
		endcase
	endfunction : stat_txt
	function automatic logic [15:0] lrow_exp(input row_t r, input logic [GRP_W-1:0] g);
		logic [15:0] v;
		int gg;
		v = '0;
		gg = (g < 3'h2) ? 1 : int'(g);
		for (int d = 0; d < NUM_DST; d++) begin
			if (d < int'(dims(g)) && r[d * gg] != SRC_MUTE) v[4 * d +: 4] = 4'((int'(r[d * gg]) - 1) / gg + 1);
		end
		return v;
	endfunction : lrow_exp
	function automatic logic [15:0] pset_exp(input logic [3:0] p, input logic l);
		if ((p == 4'h3 && !l) || (p == 4'h0 && l)) return 16'hfff0;
		return (p == 4'h3) ? 16'hf3ff : 16'hffff;
	endfunction : pset_exp
	function automatic int exp_n(input int k, input logic [2:0] f);
		case (k)
			0: return 1;
			1, 3: return 2;
			2: return $countones(LVL_CAPS[0]) + $countones(LVL_CAPS[1]);
			4, 5: return f[0] ? int'(dims(g0)) + int'(dims(g1)) : 0;
			6: return f[1] ? 2 : 0;
			7: return f[2] ? 2 * NUM_PSET : 0;
			8: return f[0] ? NUM_PSET : 0;
			11: return 1;
			default: return 0;
		endcase
	endfunction : exp_n

	// ********
	// tasks
	// ********
	task automatic check(input logic [191:0] got, input logic [191:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s got %0h expected %0h", $time, msg, got, exp);
		end
	endtask : check
	task automatic complete_run();
		if (bad_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic run_cmd(input opcode_t op, input logic [1:0] argc, input logic [31:0] a0, input logic [31:0] a1);
		int k;
		u_host_model.got_q.delete();
		saves = 0;
		@(negedge ref_clk);
		cmd_i = '{op, argc, a0, a1};
		cmd_valid = 1'b1;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 200) begin
			@(negedge ref_clk);
			k++;
		end
		check(k < 200, 1'b1, "command not taken");
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		check(cmd_ready, 1'b0, "busy after take");
		k = 0;
		while ((u_host_model.got_q.size() == 0 || u_host_model.got_q[$].kind !== SEC_PROMPT) && k < 500) begin
			@(negedge ref_clk);
			k++;
		end
		check(k < 500, 1'b1, "prompt missing");
		q = u_host_model.got_q;
	endtask : run_cmd
	task automatic check_err();
		check(q.size() == 2 && q[0].kind === SEC_ERR && saves == 0, 1'b1, "refusal");
	endtask : check_err
	task automatic pwrite(input logic [3:0] num, input logic lvl, input logic [1:0] dest, input logic [3:0] src);
		@(negedge ref_clk);
		pset_wr = '{1'b1, num, lvl, dest, src};
		@(negedge ref_clk);
		pset_wr.we = 1'b0;
	endtask : pwrite
	task automatic check_dims();
		rep_item_t it;
		run_cmd(OP_MATRIX_CONFIG_QUERY, 2'h0, 32'h0, 32'h0);
		check(q.size(), 3, "simple reply length");
		for (int l = 0; l < NUM_LVL; l++) begin
			it = q[l];
			check({it.kind, it.lvl}, {SEC_DIMS, 1'(l)}, "dims item");
			check(it.value[23:8], {dims(l ? g1 : g0), dims(l ? g1 : g0)}, "apparent size");
			check(it.value[2:0], LVL_CAPS[l], "capability sum");
		end
	endtask : check_dims
	task automatic do_reset();
		resetn = 1'b0;
		repeat (5) @(negedge ref_clk);
		check(cmd_ready, 1'b0, "ready in reset");
		resetn = 1'b1;
		pset_wr = '{1'b1, PSET_BOOT, 1'b1, 2'h0, SRC_MUTE};
		@(negedge ref_clk);
		pset_wr.we = 1'b0;
		repeat (3) @(negedge ref_clk);
		g0 = nv_in.grp[0];
		g1 = nv_in.grp[1];
		exp_route = straight;
		for (int p = 0; p < NUM_DST; p++) if (p < ((g1 < 3'h2) ? 1 : int'(g1))) exp_route[1][p] = SRC_MUTE;
		check(nv_out, nv_in, "restored settings");
		check(route, exp_route, "boot routing");
	endtask : do_reset

	// ********
	// clock, stalls, timeout
	// ********
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) begin
		rnd <= lfsr(rnd);
		stall <= rnd[0] & rnd[3];
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (nv_save === 1'b1) saves++;
		if (cycles == 20000) begin
			bad_count++;
			$display("Error at %0t: timeout", $time);
			complete_run();
		end
	end

	// ********
	// scenarios
	// ********
	initial begin
		resetn = 1'b0;
		rnd = 16'h26d2;
		stall = 1'b0;
		cmd_valid = 1'b0;
		cmd_i = '0;
		mtx_status = MS_OK;
		pset_wr = '0;
		lbl_wr = '0;
		nv_in = '{{3'h1, 3'h2}, 32'hffff_ff00};
		for (int l = 0; l < NUM_LVL; l++) for (int d = 0; d < NUM_DST; d++) straight[l][d] = SRC_W'(d + 1);
		do_reset();
		check_dims();
		run_cmd(OP_IO_GROUP_CMD, 2'h2, 32'h4, 32'h0);
		g0 = 3'h4;
		g1 = 3'h0;
		check({saves, nv_out.grp}, {32'd1, g1, g0}, "group set");
		check_dims();
		run_cmd(OP_IO_GROUP_CMD, 2'h1, 32'h3, 32'h0);
		g0 = 3'h3;
		run_cmd(OP_IO_GROUP_CMD, 2'h0, 32'h0, 32'h0);
		check({q[0].kind, q[0].value[2:0], q[1].kind, q[1].value[2:0]}, {SEC_GROUP, g0, SEC_GROUP, g1}, "group query");
		check_dims();
		run_cmd(OP_IO_GROUP_CMD, 2'h2, 32'h5, 32'h1);
		check_err();
		check(nv_out.grp, {g1, g0}, "group kept");
		mask = {rnd, lfsr(rnd)};
		run_cmd(OP_NET_MASK, 2'h1, mask, 32'h0);
		check({saves, nv_out.mask}, {32'd1, mask}, "mask set");
		run_cmd(OP_NET_MASK, 2'h0, 32'h0, 32'h0);
		check({q[0].kind, q[0].value[31:0]}, {SEC_MASK, mask}, "mask query");
		run_cmd(OP_IO_GROUP_CMD, 2'h2, 32'h2, 32'h1);
		g0 = 3'h2;
		g1 = 3'h1;
		pwrite(4'h3, 1'b0, 2'h0, SRC_MUTE);
		pwrite(4'h3, 1'b1, 2'h2, 4'h3);
		run_cmd(OP_PRESET_RECALL, 2'h1, 32'h3, 32'h0);
		exp_route[0][0] = SRC_MUTE;
		exp_route[0][1] = SRC_MUTE;
		exp_route[1][2] = 4'h3;
		check(route, exp_route, "grouped recall");
		run_cmd(OP_PRESET_RECALL, 2'h1, 32'h9, 32'h0);
		check(route, exp_route, "unassigned preset");
		run_cmd(OP_PRESET_RECALL, 2'h1, 32'ha, 32'h0);
		check_err();
		run_cmd(OP_PRESET_RECALL, 2'h0, 32'h0, 32'h0);
		check_err();
		run_cmd(OP_OTHER, 2'h0, 32'h0, 32'h0);
		check_err();
		run_cmd(OP_MATRIX_CONFIG_QUERY, 2'h1, 32'h8, 32'h0);
		check_err();
		@(negedge ref_clk);
		lbl_wr = '{1'b1, LBL_DEST, 1'b0, 4'h0, 64'h4465_7374_5f6f_6e65};
		@(negedge ref_clk);
		lbl_wr.we = 1'b0;
		for (int f = 0; f < 8; f++) begin
			mtx_status = mtx_status_t'(f[1:0]);
			run_cmd(OP_MATRIX_CONFIG_QUERY, 2'h1, 32'(f), 32'h0);
			check({q[0].kind, q[0].value}, {SEC_STATUS, stat_txt(f[1:0])}, "status word");
			check({q[1].kind, q[1].value}, {SEC_TYPE, TXT_W'("VIDEO")}, "level type");
			check({q[2].value, q[3].value}, {TXT_W'("mute"), TXT_W'("lock")}, "capability words");
			for (int k = 0; k < 12; k++) begin
				n = 0;
				foreach (q[i]) if (q[i].kind === sec_t'(k)) n++;
				check(n, exp_n(k, f[2:0]), "section count");
			end
			foreach (q[i]) begin
				if (q[i].kind === SEC_STATE) begin
					check(q[i].value[15:0], lrow_exp(exp_route[q[i].lvl], q[i].lvl ? g1 : g0), "state");
				end
				if (q[i].kind === SEC_PSET) begin
					check(q[i].value[15:0], pset_exp(q[i].idx, q[i].lvl), "preset data");
				end
			end
			if (f[0]) check({q[5].kind, q[5].value}, {SEC_DLBL, 16'h0, 64'h4465_7374_5f6f_6e65}, "label");
		end
		nv_in = '{{3'h3, 3'h0}, lfsr(rnd) ^ mask};
		do_reset();
		check_dims();
		complete_run();
	end
endmodule : router_matrix_cmd_interp_tb_top
